/* rtl/ttc_pkg.sv */
// Package for the thermal throttle controller: map, fields, timing, types
package ttc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] TTC_OFS_CTRL = 8'h00;
    localparam logic [7:0] TTC_OFS_CFG = 8'h04;
    localparam logic [7:0] TTC_OFS_OP_REQ = 8'h08;
    localparam logic [7:0] TTC_OFS_OP_TGT = 8'h0c;
    localparam logic [7:0] TTC_OFS_STATUS = 8'h10;
    // ==========================================================
    // Field positions
    localparam int TTC_CTRL_OD_EN = 4;
    localparam int TTC_CTRL_DUTY_LO = 1;
    localparam int TTC_CFG_AUTO_EN = 0;
    localparam int TTC_CFG_MODE_OP = 1;
    localparam int TTC_CFG_EV_ASSERT = 2;
    localparam int TTC_CFG_EV_DEASSERT = 3;
    localparam int TTC_ST_HOT = 0;
    localparam int TTC_ST_THROT = 1;
    localparam int TTC_ST_TRIP = 2;
    localparam int TTC_ST_DEFER = 3;
    localparam int TTC_ST_EV_ASSERT = 4;
    localparam int TTC_ST_EV_DEASSERT = 5;
    localparam int TTC_ST_OP_LO = 8;
    // ==========================================================
    // Reset values
    localparam logic [4:0] TTC_CTRL_RST = 5'h00;
    localparam logic [3:0] TTC_CFG_RST = 4'h0;
    localparam logic [7:0] TTC_OP_REQ_RST = 8'hff;
    localparam logic [7:0] TTC_OP_TGT_RST = 8'h00;
    // ==========================================================
    // Temperatures in degrees C, hidden from software
    localparam logic [7:0] TTC_TRIP_C = 8'h64;
    localparam logic [7:0] TTC_HYST_C = 8'h02;
    localparam logic [7:0] TTC_CATA_C = 8'h7d;
    // ==========================================================
    // Modulation timing
    localparam int TTC_CLK_PERIOD_NS = 20;
    localparam int TTC_SLOT_NS = 80;
    localparam int TTC_SLOT_CYC = (TTC_SLOT_NS + TTC_CLK_PERIOD_NS - 1) / TTC_CLK_PERIOD_NS;
    localparam logic [2:0] TTC_DUTY_HALF = 3'h4;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        TTC_ST_IDLE = 2'b00,
        TTC_ST_ACTIVE = 2'b01,
        TTC_ST_SHUT = 2'b11
    } ttc_state_e;

    typedef struct packed {
        logic change;
        logic [7:0] code;
    } ttc_op_s;

    typedef struct packed {
        logic ev_deassert_en;
        logic ev_assert_en;
        logic mode_op;
        logic auto_en;
    } ttc_cfg_s;
endpackage

/* rtl/ttc_duty_mod.sv */
// Clock run/stop modulator with a duty cycle in eighths
`timescale 1ns/1ps
module ttc_duty_mod #(
    parameter int SLOT_CYC = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic en,
    input wire logic [2:0] duty,
    // Result
    output logic run
);
    localparam int CW = (SLOT_CYC > 1) ? $clog2(SLOT_CYC) : 1;
    localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYC - 1);

    logic [CW-1:0] slot_reg;
    logic [2:0] eighth_reg;
    logic run_reg;

    // ==========================================================
    // Period counters, restarted whenever modulation stops
    always_ff @(posedge clock) begin
        if (!rst_n || !en) begin
            slot_reg <= '0;
            eighth_reg <= 3'h0;
        end else if (slot_reg == SLOT_LAST) begin
            slot_reg <= '0;
            eighth_reg <= eighth_reg + 3'h1;
        end else begin
            slot_reg <= slot_reg + CW'(1);
        end
    end

    // ==========================================================
    // Clocks run for the first duty eighths of each period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_reg <= 1'b1;
        end else begin
            run_reg <= !en || (eighth_reg < duty);
        end
    end

    assign run = run_reg;
endmodule

/* rtl/ttc_top.sv */
// Thermal throttle controller: trip sensing, throttling, hot and trip pins
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ttc_top #(
    parameter int IRQ_W = 8,
    parameter int SLOT_CYC = ttc_pkg::TTC_SLOT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Temperature sensor, degrees C
    input wire logic [7:0] temp_code,
    // Core side
    input wire logic lp_state,
    input wire logic [IRQ_W-1:0] irq_in,
    output logic [IRQ_W-1:0] irq_service,
    input wire logic snoop_in,
    output logic snoop_out,
    output logic core_clk_run,
    output logic core_shutdown,
    // Platform pins
    output logic die_hot_out_n,
    output logic catastrophic_trip_out_n,
    output logic thermal_event,
    // Regulator side
    output ttc_pkg::ttc_op_s op_out
);
    import ttc_pkg::*;

    // ==========================================================
    // Declarations
    logic [4:0] ctrl_reg;
    ttc_cfg_s cfg_reg;
    logic [7:0] op_req_reg;
    logic [7:0] op_tgt_reg;
    logic [31:0] rdata_reg;
    ttc_state_e state_reg;
    ttc_state_e state_next;
    logic thermal_hot_reg;
    logic pin_hot_reg;
    logic ev_assert_reg;
    logic ev_deassert_reg;
    logic event_reg;
    logic trip_reg;
    logic run_reg;
    logic [IRQ_W-1:0] pending_reg;
    logic [IRQ_W-1:0] service_reg;
    logic snoop_reg;
    ttc_op_s op_reg;
    logic [7:0] op_next;
    logic defer_reg;
    logic above_trip;
    logic below_hyst;
    logic cata_hot;
    logic auto_hot;
    logic od_on;
    logic mod_en;
    logic [2:0] mod_duty;
    logic [2:0] od_duty;
    logic op_throttle;
    logic mod_run;
    logic pin_rise;
    logic pin_fall;
    logic st_wr;
    logic [31:0] status_word;

    // ==========================================================
    // Temperature compares against fixed, unreadable thresholds
    assign above_trip = temp_code >= TTC_TRIP_C;
    assign below_hyst = temp_code < (TTC_TRIP_C - TTC_HYST_C);
    assign cata_hot = temp_code >= TTC_CATA_C;

    // ==========================================================
    // Register writes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= TTC_CTRL_RST;
            cfg_reg <= TTC_CFG_RST;
            op_req_reg <= TTC_OP_REQ_RST;
            op_tgt_reg <= TTC_OP_TGT_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                TTC_OFS_CTRL: begin
                    ctrl_reg <= reg_wdata[4:0];
                end
                TTC_OFS_CFG: begin
                    cfg_reg <= reg_wdata[3:0];
                end
                TTC_OFS_OP_REQ: begin
                    op_req_reg <= reg_wdata[7:0];
                end
                TTC_OFS_OP_TGT: begin
                    op_tgt_reg <= reg_wdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    assign st_wr = reg_wr && (reg_addr == TTC_OFS_STATUS);

    // ==========================================================
    // Thermal condition with hysteresis; it only clears once below trip minus TTC_HYST_C
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            thermal_hot_reg <= 1'b0;
        end else if (above_trip) begin
            thermal_hot_reg <= 1'b1;
        end else if (below_hyst) begin
            thermal_hot_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Mode arbitration
    assign auto_hot = cfg_reg.auto_en && thermal_hot_reg;
    assign od_on = ctrl_reg[TTC_CTRL_OD_EN];
    // Duty code 0 is undefined; it falls back to half duty
    assign od_duty = (ctrl_reg[3:1] == 3'h0) ? TTC_DUTY_HALF : ctrl_reg[3:1];
    // Automatic settings govern whenever automatic throttling is in force
    assign mod_en = auto_hot ? !cfg_reg.mode_op : od_on;
    assign mod_duty = auto_hot ? TTC_DUTY_HALF : od_duty;
    assign op_throttle = auto_hot && cfg_reg.mode_op;

    // ==========================================================
    // Top state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TTC_ST_IDLE: begin
                if (cata_hot) begin
                    state_next = TTC_ST_SHUT;
                end else if (mod_en || op_throttle) begin
                    state_next = TTC_ST_ACTIVE;
                end
            end
            TTC_ST_ACTIVE: begin
                if (cata_hot) begin
                    state_next = TTC_ST_SHUT;
                end else if (!mod_en && !op_throttle) begin
                    state_next = TTC_ST_IDLE;
                end
            end
            TTC_ST_SHUT: begin
                state_next = TTC_ST_SHUT;
            end
            default: begin
                state_next = TTC_ST_SHUT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= TTC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Catastrophic trip; held until reset, whatever the core is doing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trip_reg <= 1'b0;
        end else if (cata_hot) begin
            trip_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Clock modulation
    ttc_duty_mod #(
        .SLOT_CYC(SLOT_CYC)
    ) u_mod (
        .clock(clock),
        .rst_n(rst_n),
        .en(mod_en && !trip_reg),
        .duty(mod_duty),
        .run(mod_run)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_reg <= 1'b1;
        end else begin
            run_reg <= mod_run && !trip_reg && !cata_hot;
        end
    end

    // ==========================================================
    // Interrupts latch while clocks are stopped; a new one beats a service
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pending_reg <= '0;
            service_reg <= '0;
        end else begin
            service_reg <= run_reg ? pending_reg : '0;
            pending_reg <= (pending_reg & ~(run_reg ? pending_reg : '0)) | irq_in;
        end
    end

    // Snooping is not throttled, or coherency would suffer; only a catastrophic trip (trip_reg) blocks it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            snoop_reg <= 1'b0;
        end else begin
            snoop_reg <= snoop_in && !trip_reg;
        end
    end

    // ==========================================================
    // Operating point: software request, lowered to the thermal target only while op_throttle is set
    always_comb begin
        op_next = op_req_reg;
        if (op_throttle) begin
            if (op_req_reg > op_tgt_reg) begin
                op_next = op_tgt_reg;
            end else begin
                op_next = op_req_reg;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op_reg <= '{change: 1'b0, code: TTC_OP_REQ_RST};
            defer_reg <= 1'b0;
        end else begin
            op_reg.change <= (op_next != op_reg.code) && !trip_reg;
            if (!trip_reg) begin
                op_reg.code <= op_next;
            end
            defer_reg <= op_throttle && (op_req_reg > op_tgt_reg);
        end
    end

    // ==========================================================
    // Hot pin: frozen during low power, as the sensor clocks are stopped
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_hot_reg <= 1'b0;
        end else if (!lp_state) begin
            pin_hot_reg <= above_trip;
        end
    end

    assign pin_rise = !lp_state && above_trip && !pin_hot_reg;
    assign pin_fall = !lp_state && !above_trip && pin_hot_reg;

    // ==========================================================
    // Hot pin events; a new event beats a write-one clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ev_assert_reg <= 1'b0;
            ev_deassert_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            if (pin_rise && cfg_reg.ev_assert_en) begin
                ev_assert_reg <= 1'b1;
            end else if (st_wr && reg_wdata[TTC_ST_EV_ASSERT]) begin
                ev_assert_reg <= 1'b0;
            end
            if (pin_fall && cfg_reg.ev_deassert_en) begin
                ev_deassert_reg <= 1'b1;
            end else if (st_wr && reg_wdata[TTC_ST_EV_DEASSERT]) begin
                ev_deassert_reg <= 1'b0;
            end
            event_reg <= (pin_rise && cfg_reg.ev_assert_en) || (pin_fall && cfg_reg.ev_deassert_en);
        end
    end

    // ==========================================================
    // Register reads, data in the cycle after the strobe
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[TTC_ST_HOT] = pin_hot_reg;
        status_word[TTC_ST_THROT] = state_reg == TTC_ST_ACTIVE;
        status_word[TTC_ST_TRIP] = trip_reg;
        status_word[TTC_ST_DEFER] = defer_reg;
        status_word[TTC_ST_EV_ASSERT] = ev_assert_reg;
        status_word[TTC_ST_EV_DEASSERT] = ev_deassert_reg;
        status_word[TTC_ST_OP_LO +: 8] = op_reg.code;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                TTC_OFS_CTRL: begin
                    rdata_reg <= {27'h000_0000, ctrl_reg};
                end
                TTC_OFS_CFG: begin
                    rdata_reg <= {28'h000_0000, cfg_reg};
                end
                TTC_OFS_OP_REQ: begin
                    rdata_reg <= {24'h00_0000, op_req_reg};
                end
                TTC_OFS_OP_TGT: begin
                    rdata_reg <= {24'h00_0000, op_tgt_reg};
                end
                TTC_OFS_STATUS: begin
                    rdata_reg <= status_word;
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_reg;
    assign irq_service = service_reg;
    assign snoop_out = snoop_reg;
    assign core_clk_run = run_reg;
    assign core_shutdown = trip_reg;
    assign die_hot_out_n = !pin_hot_reg;
    assign catastrophic_trip_out_n = !trip_reg;
    assign thermal_event = event_reg;
    assign op_out = op_reg;
endmodule

/* dv/ttc_monitor.sv */
// Concurrent checks on the thermal throttle controller pins
`timescale 1ns/1ps
module ttc_monitor #(
    parameter int IRQ_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sensor and core side
    input wire logic [7:0] temp_code,
    input wire logic lp_state,
    input wire logic [IRQ_W-1:0] irq_service,
    input wire logic snoop_in,
    input wire logic snoop_out,
    input wire logic core_clk_run,
    input wire logic core_shutdown,
    // Platform and regulator side
    input wire logic die_hot_out_n,
    input wire logic catastrophic_trip_out_n,
    input wire logic thermal_event,
    input wire ttc_pkg::ttc_op_s op_out
);
    import ttc_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ====================
    // Trip and shutdown
    AST_TRIP_SET: assert property (temp_code >= TTC_CATA_C |=> !catastrophic_trip_out_n && core_shutdown)
        else $error("trip pin late");
    AST_TRIP_HELD: assert property (!catastrophic_trip_out_n |=> !catastrophic_trip_out_n && $stable(op_out.code))
        else $error("trip released or op moved");
    AST_SHUT_CLK: assert property ($rose(core_shutdown) |=> !core_clk_run [*4])
        else $error("clocks run after shutdown");
    // ====================
    // Hot pin
    AST_HOT_SET: assert property (temp_code >= TTC_TRIP_C && !lp_state |=> !die_hot_out_n)
        else $error("hot pin not set");
    AST_HOT_CLR: assert property (temp_code < TTC_TRIP_C && !lp_state |=> die_hot_out_n)
        else $error("hot pin not cleared");
    AST_LP_NO_RISE: assert property (lp_state && die_hot_out_n |=> die_hot_out_n)
        else $error("hot pin set in low power");
    AST_LP_HOLD: assert property (lp_state && !die_hot_out_n |=> !die_hot_out_n)
        else $error("hot pin dropped in low power");
    AST_EVENT: assert property (thermal_event |-> $changed(die_hot_out_n))
        else $error("event without pin edge");
    // ====================
    // Core side and regulator
    AST_SNOOP: assert property (catastrophic_trip_out_n && temp_code < TTC_CATA_C |=> snoop_out == $past(snoop_in))
        else $error("snoop lost");
    AST_IRQ_RUN: assert property (|irq_service |-> $past(core_clk_run))
        else $error("irq served while stopped");
    AST_OP_PULSE: assert property (op_out.change |-> $changed(op_out.code))
        else $error("op change without new code");
    COV_TRIP: cover property (!catastrophic_trip_out_n);
    COV_LP_HOLD: cover property (lp_state && !die_hot_out_n);
    COV_IRQ_STOP: cover property (|irq_service ##1 !core_clk_run);
endmodule

bind ttc_top ttc_monitor #(.IRQ_W(IRQ_W)) ttc_monitor_i (
    .clock(clock), .rst_n(rst_n), .temp_code(temp_code), .lp_state(lp_state),
    .irq_service(irq_service), .snoop_in(snoop_in), .snoop_out(snoop_out),
    .core_clk_run(core_clk_run), .core_shutdown(core_shutdown), .die_hot_out_n(die_hot_out_n),
    .catastrophic_trip_out_n(catastrophic_trip_out_n), .thermal_event(thermal_event), .op_out(op_out)
);

/* dv/ttc_platform_model.sv */
// Platform logic model: removes core supply after the trip pin asserts
`timescale 1ns/1ps
module ttc_platform_model #(
    parameter int OFF_CYC = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Device pin
    input wire logic catastrophic_trip_out_n,
    // Platform state
    output logic supply_on
);
    int off_cnt;
    // ====================
    // Supply cut a bounded time after trip
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            off_cnt <= 0;
            supply_on <= 1'b1;
        end else if (catastrophic_trip_out_n === 1'b0) begin
            off_cnt <= off_cnt + 1;
            supply_on <= (off_cnt < OFF_CYC - 1);
        end
    end
endmodule

/* dv/ttc_tb_top.sv */
// Self-checking bench for the thermal throttle controller
`timescale 1ns/1ps
module ttc_tb_top;
    import ttc_pkg::*;
    localparam int SLOT = 2;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] temp_code = 8'h19;
    logic lp_state = 1'b0;
    logic snoop_in = 1'b0;
    logic [7:0] irq_in = 8'h00;
    logic [7:0] served = 8'h00;
    logic [7:0] irq_service, bits;
    logic [31:0] reg_rdata, rv;
    logic snoop_out, core_clk_run, core_shutdown, die_hot_out_n;
    logic catastrophic_trip_out_n, thermal_event, supply_on;
    ttc_op_s op_out;
    int n_fail = 0;
    int checks_done = 0;
    int ev_cnt = 0;
    int req;
    logic [7:0] ra [6] = '{TTC_OFS_CTRL, TTC_OFS_CFG, TTC_OFS_OP_REQ, TTC_OFS_OP_TGT, TTC_OFS_STATUS, 8'h14};
    logic [31:0] re [6] = '{32'(TTC_CTRL_RST), 32'(TTC_CFG_RST), 32'(TTC_OP_REQ_RST),
        32'(TTC_OP_TGT_RST), 32'h0000_ff00, 32'h0000_0000};

    always #10 clock = ~clock;

    ttc_top #(.IRQ_W(8), .SLOT_CYC(SLOT)) ttc_top_i (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_code(temp_code), .lp_state(lp_state),
        .irq_in(irq_in), .irq_service(irq_service), .snoop_in(snoop_in), .snoop_out(snoop_out),
        .core_clk_run(core_clk_run), .core_shutdown(core_shutdown), .die_hot_out_n(die_hot_out_n),
        .catastrophic_trip_out_n(catastrophic_trip_out_n), .thermal_event(thermal_event), .op_out(op_out)
    );
    ttc_platform_model #(.OFF_CYC(4)) ttc_platform_model_i (
        .clock(clock), .rst_n(rst_n), .catastrophic_trip_out_n(catastrophic_trip_out_n), .supply_on(supply_on)
    );

    // ====================
    // Background traffic and observers
    always @(posedge clock) begin
        snoop_in <= 1'($urandom);
        if (thermal_event === 1'b1) ev_cnt <= ev_cnt + 1;
        if (rst_n) served <= served | irq_service;
    end

    // ====================
    // Reference model and bus tasks
    function automatic int exp_hi(int cfg, int ctrl, bit hot);
        int n;
        n = 8;
        if (ctrl[4]) n = (ctrl[3:1] == 0) ? 4 : ctrl[3:1];
        if (cfg[0] && hot) n = cfg[1] ? 8 : 4;
        return 4 * n * SLOT;
    endfunction
    function automatic int exp_op(int rq, int tg, bit hot);
        return (hot && tg < rq) ? tg : rq;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    task automatic set_in(input logic lp, input logic [7:0] t, input int w);
        @(posedge clock);
        lp_state <= lp;
        temp_code <= t;
        repeat (w) @(posedge clock);
        @(negedge clock);
    endtask
    // Counts over four whole periods, so the phase of the modulator does not matter
    task automatic duty(input int exp, input string what);
        int hi;
        hi = 0;
        repeat (16 * SLOT) @(posedge clock);
        repeat (32 * SLOT) begin
            @(negedge clock);
            hi += int'(core_clk_run === 1'b1);
        end
        chk(what, exp, hi);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        n_fail++;
        end_sim();
    end

    initial begin
        void'($urandom(98));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // ====================
        // Reset values and an unmapped place
        wr(8'h14, 32'hffff_ffff);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rv);
            chk("register", re[i], rv);
        end
        chk("pins", {1'b1, 1'b1, 1'b1, TTC_OP_REQ_RST}, {die_hot_out_n, catastrophic_trip_out_n, core_clk_run, op_out.code});
        // ====================
        // On-demand duty, every code
        set_in(1'b0, 8'(20 + $urandom % 70), 1);
        for (int n = 0; n < 8; n++) begin
            wr(TTC_OFS_CTRL, 32'(16 + 2 * n));
            duty(exp_hi(0, 16 + 2 * n, 0), "on-demand duty");
        end
        // ====================
        // Automatic clock modulation over on-demand
        wr(TTC_OFS_CFG, 32'h0000_000d);
        wr(TTC_OFS_CTRL, 32'h0000_0012);
        set_in(1'b0, TTC_TRIP_C - 8'h01, 1);
        duty(exp_hi(13, 18, 0), "below trip");
        set_in(1'b0, TTC_TRIP_C, 1);
        chk("hot pin", 0, die_hot_out_n);
        duty(exp_hi(13, 18, 1), "auto duty");
        set_in(1'b0, TTC_TRIP_C - 8'h01, 1);
        chk("hot pin", 1, die_hot_out_n);
        duty(exp_hi(13, 18, 1), "hysteresis duty");
        set_in(1'b0, TTC_TRIP_C - TTC_HYST_C - 8'h01, 1);
        duty(exp_hi(13, 18, 0), "cooled duty");
        chk("events", 2, ev_cnt);
        rd(TTC_OFS_STATUS, rv);
        chk("sticky events", 2'b11, rv[5:4]);
        wr(TTC_OFS_STATUS, 32'h0000_0030);
        rd(TTC_OFS_STATUS, rv);
        chk("cleared events", 2'b00, rv[5:4]);
        // ====================
        // Low power freezes the hot pin
        wr(TTC_OFS_CTRL, 32'h0000_0000);
        set_in(1'b1, TTC_TRIP_C + 8'($urandom % 25), 3);
        chk("hot pin", 1, die_hot_out_n);
        set_in(1'b0, TTC_TRIP_C, 1);
        chk("hot pin", 0, die_hot_out_n);
        set_in(1'b1, 8'h32, 3);
        chk("hot pin", 0, die_hot_out_n);
        set_in(1'b0, 8'h32, 1);
        chk("hot pin", 1, die_hot_out_n);
        // ====================
        // Operating point variant
        wr(TTC_OFS_CFG, 32'h0000_0003);
        wr(TTC_OFS_OP_REQ, 32'h0000_0080);
        wr(TTC_OFS_OP_TGT, 32'h0000_0040);
        set_in(1'b0, TTC_TRIP_C, 3);
        chk("op code", exp_op(128, 64, 1), op_out.code);
        duty(exp_hi(3, 0, 1), "op mode duty");
        req = 65 + $urandom % 190;
        wr(TTC_OFS_OP_REQ, 32'(req));
        set_in(1'b0, TTC_TRIP_C, 2);
        chk("op code", exp_op(req, 64, 1), op_out.code);
        rd(TTC_OFS_STATUS, rv);
        chk("status", 32'((1 << TTC_ST_HOT) | (1 << TTC_ST_THROT) | (1 << TTC_ST_DEFER)), rv & 32'h0000_000f);
        wr(TTC_OFS_OP_REQ, 32'h0000_0020);
        set_in(1'b0, TTC_TRIP_C, 2);
        chk("op code", exp_op(32, 64, 1), op_out.code);
        wr(TTC_OFS_OP_REQ, 32'(req));
        set_in(1'b0, 8'h32, 3);
        chk("op code", exp_op(req, 64, 0), op_out.code);
        // ====================
        // Interrupts latched while clocks are mostly stopped
        wr(TTC_OFS_CTRL, 32'h0000_0012);
        bits = 8'($urandom) | 8'h01;
        set_in(1'b0, 8'h32, 8);
        @(posedge clock);
        irq_in <= bits;
        @(posedge clock);
        irq_in <= 8'h00;
        repeat (16 * SLOT) @(posedge clock);
        @(negedge clock);
        chk("served irq", bits, served);
        // ====================
        // Catastrophic trip is sticky and cuts the supply
        set_in(1'b0, TTC_CATA_C + 8'($urandom % 5), 1);
        chk("trip pin", 0, catastrophic_trip_out_n);
        chk("shutdown", 1, core_shutdown);
        wr(TTC_OFS_OP_REQ, 32'h0000_0010);
        set_in(1'b0, 8'h32, 6);
        chk("trip pin", 0, catastrophic_trip_out_n);
        chk("core clocks", 0, core_clk_run);
        chk("op frozen", req, op_out.code);
        chk("supply", 0, supply_on);
        end_sim();
    end
endmodule
